//--- hdl/liu_ctrl_params.svh
/*
  constants for the line interface drive and scan port: register offsets,
  field positions, reset values and bus answers.
  assumes inclusion by bare name from the package and the design modules.
*/
`ifndef LIU_CTRL_PARAMS_SVH
`define LIU_CTRL_PARAMS_SVH

`define ADDR_W          12
`define OFF_DRIVE       12'h000
`define OFF_SCAN        12'h004
`define OFF_IRQ_STATUS  12'h008
`define OFF_IRQ_MASK    12'h00c
`define DRIVE_W         6
`define SCAN_W          3
`define DRIVE_RESET     6'h00
`define SCAN_RESET      3'h0
`define BIT_REMOTE_LOOP 0
`define BIT_LOCAL_LOOP  1
`define BIT_EQ_BYPASS   2
`define BIT_ALL_ONES    3
`define BIT_ENC_DIS     4
`define BIT_BUILD_DIS   5
`define BIT_DRV_MON     0
`define BIT_LOCK_LOST   1
`define BIT_SIG_LOSS    2
`define ZERO32          32'h0000_0000

`endif

//--- hdl/liu_ctrl_pkg.sv
/*
  types for the line interface drive and scan port: apb request and answer
  structs, drive and scan field structs.
  assumes liu_ctrl_params.svh is on the include path.
*/
`include "liu_ctrl_params.svh"

package liu_ctrl_pkg;

  // apb request from the master
  typedef struct packed {
    logic                 psel;
    logic                 penable;
    logic                 pwrite;
    logic [`ADDR_W-1:0]   paddr;
    logic [31:0]          pwdata;
  } apb_req_t;

  // apb answer to the master
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;

  // drive pins toward the line interface unit, msb first
  typedef struct packed {
    logic build_out_disable;
    logic line_encoder_disable;
    logic send_all_ones;
    logic equalizer_bypass;
    logic local_loop_select;
    logic remote_loop_select;
  } drive_t;

  // status pins from the line interface unit, msb first
  typedef struct packed {
    logic line_signal_loss;
    logic clock_recovery_lock_lost;
    logic drive_monitor_alarm;
  } scan_t;

  // loopback modes encoded as {local, remote}
  typedef enum logic [1:0] {
    loop_normal  = 2'b00,
    loop_remote  = 2'b01,
    loop_analog  = 2'b10,
    loop_digital = 2'b11
  } loop_mode_t;

endpackage : liu_ctrl_pkg

//--- hdl/scan_sync.sv
/*
  two flip-flop synchroniser for the three scan status pins.
  assumes pins are asynchronous to clock; first stage feeds only the second.
*/
`include "liu_ctrl_params.svh"
module scan_sync
  import liu_ctrl_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire liu_ctrl_pkg::scan_t pins,
  output      liu_ctrl_pkg::scan_t synced
);
  import liu_ctrl_pkg::*;

  scan_t meta;

  // two stages per bit, cleared on reset
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      meta   <= scan_t'(`SCAN_RESET);
      synced <= scan_t'(`SCAN_RESET);
    end
    else
    begin
      meta   <= pins;
      synced <= meta;
    end
  end

endmodule : scan_sync

//--- hdl/line_interface_drive_scan.sv
/*
  drive and scan port for an external line interface unit, reached over apb.
  drive register steers six output pins; scan register shows three status
  pins; scan changes raise sticky interrupt bits gated by a mask.
  assumes one clock, synchronous active-high reset, a compliant apb master.
*/
// Design decisions made here: the APB slave port and the register offsets.
// Functional notes
// - six-bit drive register, read/write, sets pins
// - read-only scan register shows three inputs
// - remote high, local low: remote loopback
// - both loop selects high: digital local loopback
// - local high, remote low: analog local loopback
// - both low: normal, no loopback
// - equalizer bypass pin from drive bit
// - all-ones pin from drive bit
// - encoder disable pin from drive bit
// - build-out disable pin from drive bit
`include "liu_ctrl_params.svh"
module line_interface_drive_scan
  import liu_ctrl_pkg::*;
(
  input  wire logic                   clock,
  input  wire logic                   rst,
  input  wire liu_ctrl_pkg::apb_req_t apb_req,
  output      liu_ctrl_pkg::apb_rsp_t apb_rsp,
  input  wire liu_ctrl_pkg::scan_t    scan_pins,
  output      liu_ctrl_pkg::drive_t   drive_pins,
  output      logic                   irq
);
  import liu_ctrl_pkg::*;

  // synchronised scan pins and their value one clock earlier
  scan_t                scan_now;
  scan_t                scan_prev;
  // interrupt side: change flags, sticky status, enable mask
  logic [`SCAN_W-1:0]   change;
  logic [`SCAN_W-1:0]   irq_status;
  logic [`SCAN_W-1:0]   irq_mask;
  logic [`SCAN_W-1:0]   status_clear;
  logic                 next_irq;
  // bus side: taken access, direction, address hits, write strobes
  logic                 access;
  logic                 wr_en;
  logic                 rd_en;
  logic                 hit_drive;
  logic                 hit_scan;
  logic                 hit_status;
  logic                 hit_mask;
  logic                 hit_any;
  logic                 drive_we;
  logic                 status_we;
  logic                 mask_we;
  // answer flops and the values they take at the taken edge
  logic                 rsp_ready;
  logic                 rsp_err;
  logic [31:0]          rsp_rdata;
  logic [31:0]          next_rdata;
  logic                 next_err;

  // scan pins cross into the clock domain; nothing here reads them raw.
  // a pin pulse shorter than a clock may be missed by the change flags
  scan_sync u_sync
  (
    .clock  (clock),
    .rst    (rst),
    .pins   (scan_pins),
    .synced (scan_now)
  );

  // an access is taken once, in the first access-phase cycle; the
  // registered ready of the next cycle masks the second sample, so
  // every transfer carries exactly one wait state and a master that
  // holds penable past pready is taken and answered again every second cycle
  assign access = apb_req.psel && apb_req.penable && !rsp_ready;
  assign wr_en  = access && apb_req.pwrite;
  assign rd_en  = access && !apb_req.pwrite;

  // register map, one aligned 32-bit word each, data in the low bits:
  //   drive       read/write, six pin levels
  //   scan        read only, three synchronised status levels
  //   irq status  sticky change flags, write one to clear
  //   irq mask    a one enables the matching status bit
  // any other address answers with pslverr and changes nothing
  assign hit_drive  = (apb_req.paddr == `OFF_DRIVE);
  assign hit_scan   = (apb_req.paddr == `OFF_SCAN);
  assign hit_status = (apb_req.paddr == `OFF_IRQ_STATUS);
  assign hit_mask   = (apb_req.paddr == `OFF_IRQ_MASK);
  assign hit_any    = hit_drive || hit_scan || hit_status || hit_mask;

  // write strobes; the scan word has none, so writes there fall away
  assign drive_we  = wr_en && hit_drive;
  assign status_we = wr_en && hit_status;
  assign mask_we   = wr_en && hit_mask;

  // drive register, which is the pin flop itself; bits 1:0 pick the
  // loopback of the line unit as {local, remote}:
  //   00 normal, 01 remote, 11 digital local, 10 analog local
  // rewriting a bit with its own value leaves the pin untouched
  always_ff @(posedge clock)
  begin
    if (rst)
      drive_pins <= drive_t'(`DRIVE_RESET);
    else if (drive_we)
    begin
      drive_pins.remote_loop_select   <= apb_req.pwdata[`BIT_REMOTE_LOOP];
      drive_pins.local_loop_select    <= apb_req.pwdata[`BIT_LOCAL_LOOP];
      drive_pins.equalizer_bypass     <= apb_req.pwdata[`BIT_EQ_BYPASS];
      drive_pins.send_all_ones        <= apb_req.pwdata[`BIT_ALL_ONES];
      drive_pins.line_encoder_disable <= apb_req.pwdata[`BIT_ENC_DIS];
      drive_pins.build_out_disable    <= apb_req.pwdata[`BIT_BUILD_DIS];
    end
  end

  // previous synced scan value for change detection
  always_ff @(posedge clock)
  begin
    if (rst)
      scan_prev <= scan_t'(`SCAN_RESET);
    else
      scan_prev <= scan_now;
  end

  // scan bits, all active high as the line unit drives them:
  //   bit 0 drive monitor alarm, no line pulses for a while
  //   bit 1 clock recovery lost its lock
  //   bit 2 line signal lost
  // either edge of a synced bit counts as a change
  assign change = scan_now ^ scan_prev;

  // write-one-to-clear strobes for the sticky status;
  // a zero bit in the written word leaves its flag alone
  assign status_clear = status_we ? apb_req.pwdata[`SCAN_W-1:0] : `SCAN_RESET;

  // sticky status, one flop per scan bit; a change in the same cycle
  // as a clear wins, so no event is lost to a racing clear
  for (genvar i = 0; i < `SCAN_W; i++)
  begin : g_status
    always_ff @(posedge clock)
    begin
      if (rst)
        irq_status[i] <= 1'b0;
      else if (change[i])
        irq_status[i] <= 1'b1;
      else if (status_clear[i])
        irq_status[i] <= 1'b0;
    end
  end

  // interrupt mask; a bit set while masked raises irq as the mask opens
  always_ff @(posedge clock)
  begin
    if (rst)
      irq_mask <= `SCAN_RESET;
    else if (mask_we)
      irq_mask <= apb_req.pwdata[`SCAN_W-1:0];
  end

  // interrupt request: any unmasked sticky bit
  assign next_irq = |(irq_status & irq_mask);

  // level interrupt from a flop, one clock behind the status;
  // clearing the status drops irq one clock later
  always_ff @(posedge clock)
  begin
    if (rst)
      irq <= 1'b0;
    else
      irq <= next_irq;
  end

  // read mux; unused upper bits read as zero
  always_comb
  begin
    next_rdata = `ZERO32;
    case (apb_req.paddr)
      `OFF_DRIVE:      next_rdata[`DRIVE_W-1:0] = drive_pins;
      `OFF_SCAN:       next_rdata[`SCAN_W-1:0]  = scan_now;
      `OFF_IRQ_STATUS: next_rdata[`SCAN_W-1:0]  = irq_status;
      `OFF_IRQ_MASK:   next_rdata[`SCAN_W-1:0]  = irq_mask;
      default:         next_rdata = `ZERO32;
    endcase
  end

  // unmapped or unaligned addresses are refused;
  // the scan word is mapped, so a write there is no error
  assign next_err = !hit_any;

  // ready pulse, one cycle after the taken access
  always_ff @(posedge clock)
  begin
    if (rst)
      rsp_ready <= 1'b0;
    else
      rsp_ready <= access;
  end

  // error pulse alongside ready; a refused access changes nothing
  always_ff @(posedge clock)
  begin
    if (rst)
      rsp_err <= 1'b0;
    else
      rsp_err <= access && next_err;
  end

  // read data only with the ready pulse of a read, zero otherwise;
  // write answers carry zero data
  always_ff @(posedge clock)
  begin
    if (rst)
      rsp_rdata <= `ZERO32;
    else
      rsp_rdata <= rd_en ? next_rdata : `ZERO32;
  end

  // answer to the master, straight from the flops above
  assign apb_rsp = '{pready: rsp_ready, pslverr: rsp_err, prdata: rsp_rdata};

endmodule : line_interface_drive_scan

//--- verification/lids_sva.sv
/* checker for the drive and scan port
   sees only the top ports, bound below */
`include "liu_ctrl_params.svh"
module lids_sva
  import liu_ctrl_pkg::*;
(
  input wire logic     clock,
  input wire logic     rst,
  input wire apb_req_t apb_req,
  input wire apb_rsp_t apb_rsp,
  input wire scan_t    scan_pins,
  input wire drive_t   drive_pins
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // taken access, answer, write, read data, drive address
  wire        a  = apb_req.psel && apb_req.penable && !apb_rsp.pready;
  wire        r  = apb_rsp.pready;
  wire        w  = apb_req.pwrite;
  wire [31:0] pd = apb_rsp.prdata;
  wire        dv = apb_req.paddr == `OFF_DRIVE;
  // any of the four mapped aligned words
  wire        mapped = apb_req.paddr inside {`OFF_DRIVE, `OFF_SCAN, `OFF_IRQ_STATUS, `OFF_IRQ_MASK};
  sequence quiet; $stable(scan_pins)[*5]; endsequence
  drv_clr_a: assert property ($fell(rst) |-> drive_pins == 6'h00) else $error("clr");
  one_wait_a: assert property (a && !$past(a) |=> r) else $error("wait");
  ready_pulse_a: assert property (r |=> !r && pd == 32'h0) else $error("pulse");
  drv_wr_a: assert property (a && w && dv |=> drive_pins == $past(apb_req.pwdata[5:0])) else $error("wr");
  drv_hold_a: assert property (!(a && w && dv) |=> $stable(drive_pins)) else $error("hold");
  drv_rd_a: assert property (r && !w && dv |-> pd == {26'h0, drive_pins}) else $error("rd");
  scan_rd_a: assert property (quiet ##0 r && !w && apb_req.paddr == `OFF_SCAN |-> pd == {29'h0, scan_pins})
    else $error("scan");
  bad_addr_a: assert property (r |-> apb_rsp.pslverr == !mapped) else $error("err");
endmodule : lids_sva
bind line_interface_drive_scan lids_sva chk (.clock(clock), .rst(rst), .apb_req(apb_req), .apb_rsp(apb_rsp),
  .scan_pins(scan_pins), .drive_pins(drive_pins));

//--- verification/liu_model.sv
/* line interface unit stand-in
   status pins follow the alarms the bench commands */
module liu_model
  import liu_ctrl_pkg::*;
(
  input wire drive_t drive,
  input wire scan_t  cond,
  output     scan_t  pins
);
  // alarms are shown level-true
  assign pins = cond;
endmodule : liu_model

//--- verification/tb.sv
/* bench for the drive and scan port
   liu_model stands in for the line interface unit */
`include "liu_ctrl_params.svh"
`define CHK(x, y) begin n_tests++; if ((x) !== (y)) begin miscompares++; $display("MISMATCH %0t compare", $time); end end
module tb
  import liu_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock = 0;
  logic        rst = 1;
  apb_req_t    req = '0;
  apb_rsp_t    rsp;
  scan_t       cond = '0;
  scan_t       pins;
  drive_t      drv;
  logic        irq;
  logic [32:0] q[$];
  int          miscompares = 0;
  int          n_tests = 0;
  logic [5:0]  d;
  logic [2:0]  s;
  // 8 ns clock
  always #4 clock = ~clock;
  line_interface_drive_scan uut (.clock(clock), .rst(rst), .apb_req(req), .apb_rsp(rsp), .scan_pins(pins),
    .drive_pins(drv), .irq(irq));
  liu_model liu (.drive(drv), .cond(cond), .pins(pins));
  task automatic print_verdict;
    $display("tests %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict
  // one apb transfer; expected {pslverr, prdata} is queued
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] v, input logic [32:0] e);
    int n;
    q.push_back(e);
    req <= '{1'b1, 1'b0, w, a, v};
    @(posedge clock);
    req.penable <= 1'b1;
    @(posedge clock);
    for (n = 0; n < 9 && rsp.pready !== 1'b1; n++)
      @(posedge clock);
    if (n == 9)
    begin
      miscompares++;
      print_verdict();
    end
    req <= '0;
    @(posedge clock);
  endtask : xfer
  // each answer against the oldest note
  always @(posedge clock)
    if (rsp.pready === 1'b1)
      `CHK({rsp.pslverr, rsp.prdata}, q.pop_front())
  initial
  begin
    void'($urandom(28));
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    `CHK(drv, 6'h00)
    // the four loop modes, then random drive words
    for (int i = 0; i < 8; i++)
    begin
      d = (i < 4) ? 6'(i) : 6'($urandom);
      xfer(1'b1, `OFF_DRIVE, {26'($urandom), d}, 33'h0);
      `CHK(drv, d)
      xfer(1'b0, `OFF_DRIVE, 32'h0, {27'h0, d});
    end
    // alarms reach the scan word; writes there are ignored
    for (int i = 0; i < 4; i++)
    begin
      s = 3'($urandom);
      cond <= s;
      repeat (4) @(posedge clock);
      xfer(1'b1, `OFF_SCAN, {29'h0, ~s}, 33'h0);
      xfer(1'b0, `OFF_SCAN, 32'h0, {30'h0, s});
    end
    xfer(1'b1, 12'h010, 32'hffff_ffff, 33'h1_0000_0000);
    `CHK(drv, d)
    // status cleared, then interrupt raised, read and masked
    xfer(1'b1, `OFF_IRQ_MASK, 32'h7, 33'h0);
    xfer(1'b1, `OFF_IRQ_STATUS, 32'h7, 33'h0);
    `CHK(irq, 1'b0)
    cond <= ~s;
    repeat (5) @(posedge clock);
    `CHK(irq, 1'b1)
    xfer(1'b0, `OFF_IRQ_STATUS, 32'h0, 33'h7);
    xfer(1'b1, `OFF_IRQ_MASK, 32'h0, 33'h0);
    `CHK(irq, 1'b0)
    print_verdict();
  end
endmodule : tb
